// [core/spi_port_pkg.sv]
/*
 * shared constants for the serial slave register port and its host end.
 * assumes one 10 MHz system clock for both ends and a bench that joins them.
 */
package spi_port_pkg;
    // system clock
    localparam int CLK_PERIOD_NS = 100;
    // busy window after reset
    localparam int BUSY_MS       = 350;
    localparam int BUSY_CYCLES   = BUSY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUSY_W        = 22;
    // least gap between two selects, rounded up
    localparam int SS_GAP_NS     = 200;
    localparam int SS_GAP_CYCLES = (SS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // serial clock made by the host
    localparam int SCK_MAX_MHZ   = 25;
    localparam int SCK_PERIOD_NS = 1600;
    localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int TMR_W         = 22;
    // frame layout
    localparam int XFER_BITS     = 24;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] BYTE_CMD  = 2'h0;
    localparam logic [1:0] BYTE_ADDR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;
    // command byte fields
    localparam int CMD_RW_BIT    = 0;
    localparam int CMD_MODE_BIT  = 4;
    localparam int CMD_ID_LSB    = 1;
    localparam int CMD_ID_MSB    = 3;
    localparam int CMD_TOP_LSB   = 5;
    localparam int CMD_TOP_MSB   = 7;
    localparam logic [2:0] CMD_NORMAL_TAG = 3'h3;
    localparam logic [2:0] CHIP_ID        = 3'h0;
    // paging: each page spans 256 byte addresses
    localparam int PAGE_BYTES    = 256;
    localparam logic [7:0] PAGE_REG_ADDR  = 8'hff;
    localparam logic [7:0] PAGE_RESET     = 8'h00;
    // strap sampled once the synchroniser has filled
    localparam logic [1:0] STRAP_SYNC_CYCLES = 2'h2;
endpackage : spi_port_pkg

// [core/spi_link_if.sv]
/*
 * the four-wire serial link between host and device.
 * assumes a pull-up on the shared master-in wire when no slave drives it.
 */
interface spi_link_if;
    logic ss_n;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso;

    // released line floats high through the pull-up
    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport dev (
        input  ss_n,
        input  sck,
        input  mosi,
        output miso_o,
        output miso_oe_n
    );

    modport host (
        output ss_n,
        output sck,
        output mosi,
        input  miso
    );
endinterface : spi_link_if

// [core/spi_reg_port.sv]
/*
 * device end: serial slave port onto the paged register space, with
 * strap-selected loader path and a busy window after reset.
 * assumes the host makes sck no faster than a few system clocks per half.
 */
module spi_reg_port
    import spi_port_pkg::*;
#(
    parameter int BUSY_CYCLES_P = BUSY_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    spi_link_if.dev         link,
    input  wire logic       strap_host_sel,
    input  wire logic       ee_wr,
    input  wire logic [7:0] ee_page,
    input  wire logic [7:0] ee_addr,
    input  wire logic [7:0] ee_wdata,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_page,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            host_mode,
    output logic            port_busy
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic              ss_m;
        logic              ss_s;
        logic              ss_d;
        logic              sck_m;
        logic              sck_s;
        logic              sck_d;
        logic              mosi_m;
        logic              mosi_s;
        logic              strap_m;
        logic              strap_s;
        logic [1:0]        cap_cnt;
        logic              captured;
        logic              spi_en;
        logic [BUSY_W-1:0] busy_cnt;
        logic              active;
        logic              cmd_ok;
        logic [2:0]        bit_cnt;
        logic [1:0]        byte_cnt;
        logic [7:0]        rx;
        logic [7:0]        tx;
        logic [7:0]        cmd;
        logic [7:0]        addr;
        logic [7:0]        page;
        logic              rd_load;
        logic              miso;
        logic              wr;
        logic              rd;
        logic [7:0]        out_addr;
        logic [7:0]        wdata;
    } dev_state_t;

    localparam dev_state_t RESET_ST = '{
        ss_m:     1'b1,
        ss_s:     1'b1,
        ss_d:     1'b1,
        sck_m:    1'b1,
        sck_s:    1'b1,
        sck_d:    1'b1,
        mosi_m:   1'b0,
        mosi_s:   1'b0,
        strap_m:  1'b1,
        strap_s:  1'b1,
        cap_cnt:  2'h0,
        captured: 1'b0,
        spi_en:   1'b0,
        busy_cnt: BUSY_W'(BUSY_CYCLES_P),
        active:   1'b0,
        cmd_ok:   1'b0,
        bit_cnt:  3'h0,
        byte_cnt: BYTE_CMD,
        rx:       8'h00,
        tx:       8'h00,
        cmd:      8'h00,
        addr:     8'h00,
        page:     PAGE_RESET,
        rd_load:  1'b0,
        miso:     1'b1,
        wr:       1'b0,
        rd:       1'b0,
        out_addr: 8'h00,
        wdata:    8'h00
    };

    dev_state_t cur;
    dev_state_t next;

    logic       ss_fall;
    logic       sck_rise;
    logic       sck_fall;
    logic       port_ok;
    logic       is_write;
    logic       is_fast;
    logic [7:0] rx_byte;
    logic [7:0] start_addr;

    ////////////////////////////////////////////////////////////////////////
    // decode

    always_comb begin
        ss_fall    = cur.ss_d & ~cur.ss_s;
        sck_rise   = ~cur.sck_d & cur.sck_s;
        sck_fall   = cur.sck_d & ~cur.sck_s;
        port_ok    = cur.captured & cur.spi_en & (cur.busy_cnt == '0);
        is_write   = cur.cmd[CMD_RW_BIT];
        is_fast    = cur.cmd[CMD_MODE_BIT];
        rx_byte    = {cur.rx[6:0], cur.mosi_s};
        start_addr = rx_byte;
        if (is_fast && !is_write) begin
            start_addr = rx_byte + {5'h00, cur.cmd[CMD_TOP_MSB:CMD_TOP_LSB]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next         = cur;
        next.wr      = 1'b0;
        next.rd      = 1'b0;
        next.rd_load = 1'b0;

        // pins from the host's domain
        next.ss_m    = link.ss_n;
        next.ss_s    = cur.ss_m;
        next.ss_d    = cur.ss_s;
        next.sck_m   = link.sck;
        next.sck_s   = cur.sck_m;
        next.sck_d   = cur.sck_s;
        next.mosi_m  = link.mosi;
        next.mosi_s  = cur.mosi_m;
        next.strap_m = strap_host_sel;
        next.strap_s = cur.strap_m;

        if (!cur.captured) begin
            if (cur.cap_cnt == STRAP_SYNC_CYCLES) begin
                next.captured = 1'b1;
                next.spi_en   = cur.strap_s;
            end else begin
                next.cap_cnt = cur.cap_cnt + 2'h1;
            end
        end

        if (cur.busy_cnt != '0) begin
            next.busy_cnt = cur.busy_cnt - BUSY_W'(1);
        end

        if (cur.captured && !cur.spi_en) begin
            next.wr       = ee_wr;
            next.out_addr = ee_addr;
            next.wdata    = ee_wdata;
            next.page     = ee_page;
        end

        if (cur.rd_load) begin
            next.tx = reg_rdata;
        end

        if (cur.ss_s) begin
            next.active = 1'b0;
        end

        if (ss_fall) begin
            next.active   = port_ok;
            next.bit_cnt  = 3'h0;
            next.byte_cnt = BYTE_CMD;
            next.tx       = 8'h00;
            next.cmd_ok   = 1'b0;
        end

        if (cur.active && !cur.ss_s && sck_rise) begin
            next.rx      = rx_byte;
            next.bit_cnt = cur.bit_cnt + 3'h1;
            if (cur.bit_cnt == LAST_BIT) begin
                case (cur.byte_cnt)
                    BYTE_CMD: begin
                        next.cmd      = rx_byte;
                        next.cmd_ok   = (rx_byte[CMD_ID_MSB:CMD_ID_LSB] == CHIP_ID) &&
                                        (rx_byte[CMD_MODE_BIT] ||
                                         rx_byte[CMD_TOP_MSB:CMD_TOP_LSB] == CMD_NORMAL_TAG);
                        next.byte_cnt = BYTE_ADDR;
                    end
                    BYTE_ADDR: begin
                        next.addr     = start_addr;
                        next.byte_cnt = BYTE_DATA;
                        if (cur.cmd_ok && !is_write) begin
                            next.rd       = 1'b1;
                            next.rd_load  = 1'b1;
                            next.out_addr = start_addr;
                        end
                    end
                    BYTE_DATA: begin
                        next.addr = cur.addr + 8'h01;
                        if (cur.cmd_ok && is_write) begin
                            next.wr       = 1'b1;
                            next.out_addr = cur.addr;
                            next.wdata    = rx_byte;
                            if (cur.addr == PAGE_REG_ADDR) begin
                                next.page = rx_byte;
                            end
                        end else if (cur.cmd_ok) begin
                            next.rd       = 1'b1;
                            next.rd_load  = 1'b1;
                            next.out_addr = cur.addr + 8'h01;
                        end
                    end
                    default: begin
                        next.byte_cnt = BYTE_DATA;
                    end
                endcase
            end
        end

        if (cur.active && !cur.ss_s && sck_fall) begin
            next.miso = cur.tx[7];
            next.tx   = {cur.tx[6:0], 1'b0};
        end
    end

    // sck synchronised with idle-high reset value
    always_ff @(posedge clk) begin
        if (reset) begin
            cur <= RESET_ST;
        end else begin
            cur <= next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign link.miso_o    = cur.miso;
    assign link.miso_oe_n = ~cur.active;
    assign reg_wr         = cur.wr;
    assign reg_rd         = cur.rd;
    assign reg_page       = cur.page;
    assign reg_addr       = cur.out_addr;
    assign reg_wdata      = cur.wdata;
    assign host_mode      = cur.spi_en;
    assign port_busy      = ~port_ok;

endmodule : spi_reg_port

// [core/spi_host_end.sv]
/*
 * host end: serial master making select and a divided clock, one
 * three-byte transfer (command, address, one data byte) per request.
 * assumes the device end runs on the same system clock rate.
 */
module spi_host_end
    import spi_port_pkg::*;
#(
    parameter int BOOT_CYCLES_P = BUSY_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    spi_link_if.host        link,
    input  wire logic       start,
    input  wire logic [7:0] start_cmd,
    input  wire logic [7:0] start_addr,
    input  wire logic [7:0] start_wdata,
    output logic            ready,
    output logic            done,
    output logic [7:0]      rdata
);

    typedef enum logic [2:0] {
        H_BOOT,
        H_IDLE,
        H_SETUP,
        H_LOW,
        H_HIGH,
        H_GAP
    } host_phase_t;

    typedef struct packed {
        host_phase_t          st;
        logic [TMR_W-1:0]     tmr;
        logic [4:0]           bit_cnt;
        logic [XFER_BITS-1:0] sh;
        logic [7:0]           rx;
        logic                 ss_n;
        logic                 sck;
        logic                 mosi;
        logic                 miso_m;
        logic                 miso_s;
        logic                 done;
        logic [7:0]           rdata;
    } host_state_t;

    localparam logic [TMR_W-1:0] HALF_T = TMR_W'(SCK_HALF_CYCLES - 1);
    localparam logic [TMR_W-1:0] GAP_T  = TMR_W'(SS_GAP_CYCLES - 1);
    localparam logic [4:0]       NBITS  = 5'(XFER_BITS);

    localparam host_state_t RESET_ST = '{
        st:      H_BOOT,
        tmr:     TMR_W'(BOOT_CYCLES_P),
        bit_cnt: 5'h00,
        sh:      '0,
        rx:      8'h00,
        ss_n:    1'b1,
        sck:     1'b1,
        mosi:    1'b0,
        miso_m:  1'b1,
        miso_s:  1'b1,
        done:    1'b0,
        rdata:   8'h00
    };

    host_state_t cur;
    host_state_t next;

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        next        = cur;
        next.done   = 1'b0;
        next.miso_m = link.miso;
        next.miso_s = cur.miso_m;
        if (cur.tmr != '0) begin
            next.tmr = cur.tmr - TMR_W'(1);
        end
        case (cur.st)
            H_BOOT: begin
                if (cur.tmr == '0) begin
                    next.st = H_IDLE;
                end
            end
            H_IDLE: begin
                if (start) begin
                    next.ss_n    = 1'b0;
                    next.sh      = {start_cmd, start_addr, start_wdata};
                    next.bit_cnt = 5'h00;
                    next.tmr     = HALF_T;
                    next.st      = H_SETUP;
                end
            end
            H_SETUP, H_HIGH: begin
                if (cur.tmr == '0) begin
                    if (cur.bit_cnt == NBITS) begin
                        next.ss_n  = 1'b1;
                        next.done  = 1'b1;
                        next.rdata = cur.rx;
                        next.tmr   = GAP_T;
                        next.st    = H_GAP;
                    end else begin
                        next.sck  = 1'b0;
                        next.mosi = cur.sh[XFER_BITS-1];
                        next.sh   = {cur.sh[XFER_BITS-2:0], 1'b0};
                        next.tmr  = HALF_T;
                        next.st   = H_LOW;
                    end
                end
            end
            H_LOW: begin
                if (cur.tmr == '0) begin
                    next.sck     = 1'b1;
                    next.rx      = {cur.rx[6:0], cur.miso_s};
                    next.bit_cnt = cur.bit_cnt + 5'h01;
                    next.tmr     = HALF_T;
                    next.st      = H_HIGH;
                end
            end
            H_GAP: begin
                if (cur.tmr == '0) begin
                    next.st = H_IDLE;
                end
            end
            default: begin
                next.st = H_IDLE;
            end
        endcase
    end

    // sck only from the divider above, idle high
    always_ff @(posedge clk) begin
        if (reset) begin
            cur <= RESET_ST;
        end else begin
            cur <= next;
        end
    end

    assign link.ss_n = cur.ss_n;
    assign link.sck  = cur.sck;
    assign link.mosi = cur.mosi;
    assign ready     = (cur.st == H_IDLE);
    assign done      = cur.done;
    assign rdata     = cur.rdata;

endmodule : spi_host_end

// [testbench/spi_link_sva.sv]
/*
 * concurrent checks on the serial link joining host end and device end.
 * assumes the bench instantiates it beside the link interface, same clock.
 */
module spi_link_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic ss_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking dflt @(posedge clk);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////
    // sck falls seen inside the current select
    logic [4:0] falls;
    always_ff @(posedge clk) begin
        if (reset || ss_n) begin
            falls <= 5'h00;
        end else if ($fell(sck)) begin
            falls <= falls + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////
    a_sck_idle_high: assert property (ss_n |-> sck)
        else $error("sck low while deselected");
    a_miso_released: assert property (ss_n [*5] |-> miso_oe_n)
        else $error("miso driven while deselected");
    a_mosi_on_fall: assert property (
        !ss_n && $past(!ss_n) && $changed(mosi) |-> $fell(sck))
        else $error("mosi changed off a falling sck");
    a_miso_while_low: assert property (
        !miso_oe_n && $past(!miso_oe_n) && $changed(miso_o) |-> !sck)
        else $error("miso changed while sck high");
    a_sck_half_width: assert property ($fell(sck) |-> !sck [*8] ##1 sck)
        else $error("sck low half not eight clocks");
    a_select_gap: assert property ($rose(ss_n) |-> ss_n [*2])
        else $error("select gap under two clocks");
    a_frame_bits: assert property ($rose(ss_n) |-> falls == 5'h18)
        else $error("frame not three whole bytes");
    a_select_first: assert property ($fell(ss_n) |-> sck [*8] ##1 !sck)
        else $error("select not taken while sck high");

    c_select: cover property ($fell(ss_n));
    c_miso_driven: cover property ($fell(miso_oe_n));
    c_frame_end: cover property ($rose(ss_n) && falls == 5'h18);
endmodule : spi_link_sva

// [testbench/test_spi_slave_register_port.sv]
/*
 * bench: host end and device end joined by the link, small register space model.
 * assumes the core package and link interface are compiled first.
 */
module test_spi_slave_register_port
    import spi_port_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk            = 1'b0;
    logic        reset          = 1'b1;
    logic        strap_host_sel = 1'b1;
    logic        ee_wr          = 1'b0;
    logic [7:0]  ee_page        = 8'h00;
    logic [7:0]  ee_addr        = 8'h00;
    logic [7:0]  ee_wdata       = 8'h00;
    logic [7:0]  reg_rdata;
    logic        start          = 1'b0;
    logic [7:0]  start_cmd      = 8'h00;
    logic [7:0]  start_addr     = 8'h00;
    logic [7:0]  start_wdata    = 8'h00;
    logic        reg_wr, reg_rd, host_mode, port_busy, ready, done;
    logic [7:0]  reg_page, reg_addr, reg_wdata, rdata, wr_a, wr_d, rd_a;
    logic [23:0] mosi_sr;
    int          fails = 0, n_tests = 0, wr_n = 0, rd_n = 0, wr0 = 0, rd_base = 0;
    logic [7:0]  wd_tab [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    spi_link_if link ();
    spi_reg_port #(.BUSY_CYCLES_P(20)) i_spi_reg_port (.clk(clk), .reset(reset), .link(link),
        .strap_host_sel(strap_host_sel), .ee_wr(ee_wr), .ee_page(ee_page), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .host_mode(host_mode), .port_busy(port_busy));
    spi_host_end #(.BOOT_CYCLES_P(24)) i_spi_host_end (.clk(clk), .reset(reset), .link(link),
        .start(start), .start_cmd(start_cmd), .start_addr(start_addr),
        .start_wdata(start_wdata), .ready(ready), .done(done), .rdata(rdata));
    spi_link_sva i_spi_link_sva (.clk(clk), .reset(reset), .ss_n(link.ss_n), .sck(link.sck),
        .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n));

    ////////////////////////////////////////////////////////////
    // register space: strobes recorded, read data answers within the reg_rd cycle
    assign reg_rdata = reg_addr ^ 8'hc3;
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            wr_n <= wr_n + 1;
            wr_a <= reg_addr;
            wr_d <= reg_wdata;
        end
        if (reg_rd === 1'b1) begin
            if (rd_n == rd_base) rd_a <= reg_addr;
            rd_n <= rd_n + 1;
        end
    end
    // bits seen on mosi at sck rises, last three bytes kept
    always @(posedge link.sck) if (link.ss_n === 1'b0) mosi_sr <= {mosi_sr[22:0], link.mosi};

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_hi(input int which);
        int i;
        for (i = 0; i <= 600; i++) begin
            @(negedge clk);
            if ((which == 0 ? ready : done) === 1'b1) break;
        end
        if (i > 600) begin
            fails++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            tally_and_finish();
        end
    endtask : wait_hi

    task automatic do_reset();
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] wd);
        wait_hi(0);
        wr0 = wr_n;
        rd_base = rd_n;
        @(posedge clk);
        start_cmd <= cmd;
        start_addr <= addr;
        start_wdata <= wd;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_hi(1);
    endtask : xfer

    ////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        repeat (5) @(negedge clk);
        chk(24'(host_mode), 24'h1, "strap capture");
        chk(24'(port_busy), 24'h1, "busy after reset");
        wait_hi(0);
        chk(24'(port_busy), 24'h0, "busy over");
        $display("test reset done");
        xfer(8'h61, 8'h10, 8'h5a);
        chk(24'(wr_n - wr0), 24'h1, "one write strobe");
        chk(24'(wr_a), 24'h10, "write address");
        chk(24'(wr_d), 24'h5a, "write data");
        chk(mosi_sr, 24'h6110_5a, "mosi frame msb first");
        $display("test write done");
        for (int k = 0; k < 4; k++) begin
            xfer(8'h61, 8'h40 + 8'(k), wd_tab[k]);
            chk(24'({wr_a, wr_d}), 24'({8'h40 + 8'(k), wd_tab[k]}), "back to back");
        end
        $display("test back to back done");
        xfer(8'h60, 8'h20, 8'h00);
        chk(24'(rd_a), 24'h20, "read address");
        chk(24'(rd_n - rd_base), 24'h2, "read strobes");
        chk(24'(rdata), 24'he3, "read data on miso");
        chk(24'(wr_n - wr0), 24'h0, "no write on read");
        xfer(8'h50, 8'h20, 8'h00);
        chk(24'(rd_a), 24'h22, "offset read address");
        chk(24'(rdata), 24'he1, "offset read data");
        xfer(8'h62, 8'h20, 8'h00);
        chk(24'(rd_n - rd_base), 24'h0, "bad chip id no read");
        chk(24'(rdata), 24'h00, "bad chip id zeros");
        $display("test read done");
        xfer(8'h61, 8'hff, 8'h10);
        chk(24'(reg_page), 24'h10, "page select");
        $display("test page done");
        @(posedge clk);
        strap_host_sel <= 1'b0;
        do_reset();
        wait_hi(0);
        chk(24'(host_mode), 24'h0, "loader strap");
        chk(24'(port_busy), 24'h1, "serial refused");
        xfer(8'h61, 8'h30, 8'h11);
        chk(24'(wr_n - wr0), 24'h0, "no serial strobe");
        chk(24'(rdata), 24'hff, "miso released");
        @(posedge clk);
        ee_page <= 8'h02;
        ee_addr <= 8'h40;
        ee_wdata <= 8'h99;
        ee_wr <= 1'b1;
        @(posedge clk);
        ee_wr <= 1'b0;
        repeat (3) @(negedge clk);
        chk(24'({reg_page, wr_a, wr_d}), 24'h0240_99, "loader reaches registers");
        $display("test loader done");
        tally_and_finish();
    end
endmodule : test_spi_slave_register_port
